//--- verilog/srs_seq.sv
/*
 * Start-up sequencer and memory execution violation reset.
 * Holds the core in reset after power-on or brown-out until the power-up
 * timer, oscillator start-up timer and master clear pin allow it, and
 * resets the core when it executes from outside the valid region.
 * Assumes synchronous inputs, one 10 MHz clock and an AXI4-Lite master.
 */
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module srs_seq #(
	parameter int unsigned PWRT_COUNT = srs_pkg::PWRT_CYC,
	parameter int unsigned OST_COUNT = srs_pkg::OST_CYC,
	parameter int unsigned AW = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic por_event,
	input wire logic brownout_reset,
	input wire logic master_clear_pin_n,
	input wire srs_pkg::srs_core_s core,
	output logic core_rst_n,
	output logic irq_take,
	output logic exec_violation_rst,
	input wire srs_pkg::srs_axi_req_s axi_req,
	output srs_pkg::srs_axi_rsp_s axi_rsp
);

	initial begin
		if (AW != 16) begin
			$error("srs_seq supports AW of 16 only");
		end
		if (PWRT_COUNT < 1 || OST_COUNT < 1) begin
			$error("srs_seq timer counts must be at least 1");
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_POWERUP,
		ST_HOLD,
		ST_RUN
	} srs_state_e;

	typedef struct packed {
		srs_state_e st;
		logic exv_flag;
		logic [3:0] cfg;
		logic [15:0] limit;
		logic [15:0] saf_base;
		logic viol;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} srs_seq_s;

	srs_seq_s s_q;
	srs_seq_s s_d;

	logic pwrt_done;
	logic ost_done;
	logic addr_bad;
	logic restart;
	logic viol_now;
	logic master_clear_pin_ok;
	logic wr_fire;
	logic rd_fire;

	// ----------------------------------------------------------------
	// Start-up timers
	// ----------------------------------------------------------------
	// Only power events restart the timers; the pin does not
	assign restart = por_event || brownout_reset;

	srs_timer #(
		.COUNT(PWRT_COUNT)
	) u_pwrt (
		.clk(clk),
		.nrst(nrst),
		.restart(restart),
		.enable(s_q.cfg[srs_pkg::CFG_PWRT_EN_BIT]),
		.done(pwrt_done)
	);

	srs_timer #(
		.COUNT(OST_COUNT)
	) u_ost (
		.clk(clk),
		.nrst(nrst),
		.restart(restart),
		.enable(s_q.cfg[srs_pkg::CFG_OST_REQ_BIT]),
		.done(ost_done)
	);

	// ----------------------------------------------------------------
	// Region check
	// ----------------------------------------------------------------
	srs_region #(
		.AW(AW)
	) u_region (
		.addr(core.exec_addr),
		.limit(s_q.limit),
		.saf_base(s_q.saf_base),
		.saf_en(s_q.cfg[srs_pkg::CFG_SAF_EN_BIT]),
		.invalid(addr_bad)
	);

	// Only an executed instruction counts, never a bare prefetch
	assign viol_now = (s_q.st == ST_RUN) && core.exec_valid &&
		addr_bad;

	// Pin low means asserted; a disabled pin never holds the core
	assign master_clear_pin_ok = !s_q.cfg[srs_pkg::CFG_MASTER_CLEAR_PIN_EN_BIT] ||
		master_clear_pin_n;

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Violation pulls core reset in the same cycle, no interrupt passes
	assign core_rst_n = (s_q.st == ST_RUN) && !viol_now;
	assign irq_take = core.irq_req && core_rst_n;
	assign exec_violation_rst = s_q.viol;

	assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign rd_fire = axi_req.arvalid && !s_q.rvalid;

	assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
	assign axi_rsp.wready = !s_q.w_got && !s_q.bvalid;
	assign axi_rsp.bvalid = s_q.bvalid;
	assign axi_rsp.bresp = s_q.bresp;
	assign axi_rsp.arready = !s_q.rvalid;
	assign axi_rsp.rvalid = s_q.rvalid;
	assign axi_rsp.rdata = s_q.rdata;
	assign axi_rsp.rresp = s_q.rresp;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Hardware clear of the flag wins over a software write-one
	always_comb begin
		s_d = s_q;
		s_d.viol = viol_now;

		// Sequencer
		unique case (s_q.st)
			ST_POWERUP: begin
				if (pwrt_done && ost_done) begin
					s_d.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (master_clear_pin_ok) begin
					s_d.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!master_clear_pin_ok) begin
					s_d.st = ST_HOLD;
				end
			end
		endcase
		if (restart) begin
			s_d.st = ST_POWERUP;
		end

		// Write channel capture
		if (axi_req.awvalid && axi_rsp.awready) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			s_d.w_got = 1'b1;
			s_d.w_data = axi_req.wdata;
			s_d.w_strb = axi_req.wstrb;
		end
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = srs_pkg::RESP_OKAY;
			unique case (s_q.aw_addr)
				srs_pkg::OFS_POWER_CONTROL_REG_1: begin
					if (s_q.w_strb[0] &&
						s_q.w_data[srs_pkg::POWER_CONTROL_REG_1_EXV_BIT]) begin
						s_d.exv_flag = 1'b1;
					end
				end
				srs_pkg::OFS_CFG: begin
					if (s_q.w_strb[0]) begin
						s_d.cfg = s_q.w_data[3:0];
					end
				end
				srs_pkg::OFS_STAT: begin
				end
				srs_pkg::OFS_LIMIT: begin
					if (s_q.w_strb[0]) begin
						s_d.limit[7:0] = s_q.w_data[7:0];
					end
					if (s_q.w_strb[1]) begin
						s_d.limit[15:8] = s_q.w_data[15:8];
					end
				end
				srs_pkg::OFS_SAF_BASE: begin
					if (s_q.w_strb[0]) begin
						s_d.saf_base[7:0] = s_q.w_data[7:0];
					end
					if (s_q.w_strb[1]) begin
						s_d.saf_base[15:8] = s_q.w_data[15:8];
					end
				end
				default: begin
					s_d.bresp = srs_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && axi_req.bready) begin
			s_d.bvalid = 1'b0;
		end

		// Read channel
		if (rd_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = srs_pkg::RESP_OKAY;
			s_d.rdata = '0;
			unique case (axi_req.araddr)
				srs_pkg::OFS_POWER_CONTROL_REG_1: begin
					s_d.rdata[srs_pkg::POWER_CONTROL_REG_1_EXV_BIT] = s_q.exv_flag;
				end
				srs_pkg::OFS_CFG: begin
					s_d.rdata[3:0] = s_q.cfg;
				end
				srs_pkg::OFS_STAT: begin
					s_d.rdata[srs_pkg::STAT_PWRT_DONE_BIT] = pwrt_done;
					s_d.rdata[srs_pkg::STAT_OST_DONE_BIT] = ost_done;
					s_d.rdata[srs_pkg::STAT_RUN_BIT] = (s_q.st == ST_RUN);
				end
				srs_pkg::OFS_LIMIT: begin
					s_d.rdata[15:0] = s_q.limit;
				end
				srs_pkg::OFS_SAF_BASE: begin
					s_d.rdata[15:0] = s_q.saf_base;
				end
				default: begin
					s_d.rresp = srs_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_q.rvalid && axi_req.rready) begin
			s_d.rvalid = 1'b0;
		end

		// Violation clears the cause flag, overriding any write
		if (viol_now) begin
			s_d.exv_flag = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Flag resets to one: no violation seen since power-up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.st <= ST_POWERUP;
			s_q.exv_flag <= 1'b1;
			s_q.cfg <= srs_pkg::CFG_RST;
			s_q.limit <= srs_pkg::LIMIT_RST;
			s_q.saf_base <= srs_pkg::SAF_BASE_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule // srs_seq

//--- verilog/srs_pkg.sv
/*
 * Shared constants, register map and carrier structs for the start-up
 * sequencer and execution-violation reset block.
 * Assumes a single 10 MHz clock and an AXI4-Lite register master.
 */
package srs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned PWRT_US = 64;
	localparam int unsigned OST_CYCLES_OSC = 1024;
	localparam int unsigned PWRT_CYC = (PWRT_US * (CLK_HZ / 1_000_000));
	localparam int unsigned OST_CYC = OST_CYCLES_OSC;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_POWER_CONTROL_REG_1 = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_LIMIT = 8'h0C;
	localparam logic [7:0] OFS_SAF_BASE = 8'h10;

	// Field positions
	localparam int unsigned POWER_CONTROL_REG_1_EXV_BIT = 1;
	localparam int unsigned CFG_PWRT_EN_BIT = 0;
	localparam int unsigned CFG_OST_REQ_BIT = 1;
	localparam int unsigned CFG_MASTER_CLEAR_PIN_EN_BIT = 2;
	localparam int unsigned CFG_SAF_EN_BIT = 3;
	localparam int unsigned STAT_PWRT_DONE_BIT = 0;
	localparam int unsigned STAT_OST_DONE_BIT = 1;
	localparam int unsigned STAT_RUN_BIT = 2;

	// Reset values
	localparam logic [3:0] CFG_RST = 4'h7;
	localparam logic [15:0] LIMIT_RST = 16'h8000;
	localparam logic [15:0] SAF_BASE_RST = 16'h7F80;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} srs_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} srs_axi_rsp_s;

	// Core fetch/execute view
	typedef struct packed {
		logic exec_valid;
		logic [15:0] exec_addr;
		logic irq_req;
	} srs_core_s;

endpackage

//--- verilog/srs_timer.sv
/*
 * One-shot start-up timer: counts from a start pulse to a done level.
 * Assumes start is held or pulsed while the sequencer is in power-up.
 */
`timescale 1ns/10ps
module srs_timer #(
	parameter int unsigned COUNT = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic restart,
	input wire logic enable,
	output logic done
);

	localparam int unsigned W = $clog2(COUNT + 1);

	initial begin
		if (COUNT < 1) begin
			$error("srs_timer COUNT must be at least 1");
		end
	end

	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} srs_tmr_s;

	srs_tmr_s s_q;
	srs_tmr_s s_d;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// Disabled timer reports done at once so it never blocks start-up
	always_comb begin
		s_d = s_q;
		if (restart) begin
			s_d.cnt = '0;
			s_d.done = 1'b0;
		end else if (!enable) begin
			s_d.done = 1'b1;
		end else if (!s_q.done) begin
			if (s_q.cnt == W'(COUNT - 1)) begin
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + W'(1);
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;

endmodule // srs_timer

//--- verilog/srs_region.sv
/*
 * Valid execution region check for one fetch address.
 * Assumes limit and storage-area base are stable software settings.
 */
`timescale 1ns/10ps
module srs_region #(
	parameter int unsigned AW = 16
) (
	input wire logic [AW-1:0] addr,
	input wire logic [AW-1:0] limit,
	input wire logic [AW-1:0] saf_base,
	input wire logic saf_en,
	output logic invalid
);

	// Beyond implemented flash, or inside enabled storage area
	always_comb begin
		invalid = (addr >= limit) ||
			(saf_en && (addr >= saf_base) && (addr < limit));
	end

endmodule // srs_region

//--- test/srs_seq_checker.sv
/*
 * Assertion checker for the start-up sequencer, bound to srs_seq.
 * Assumes CFG stays at its reset timer settings while it watches.
 */
`timescale 1ns/10ps
module srs_seq_checker #(
	parameter int unsigned PWRT_COUNT = 4,
	parameter int unsigned OST_COUNT = 6,
	parameter int unsigned AW = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic por_event,
	input wire logic brownout_reset,
	input wire logic master_clear_pin_n,
	input wire srs_pkg::srs_core_s core,
	input wire logic core_rst_n,
	input wire logic irq_take,
	input wire logic exec_violation_rst,
	input wire srs_pkg::srs_axi_req_s axi_req,
	input wire srs_pkg::srs_axi_rsp_s axi_rsp
);
	localparam int unsigned MAXT = (PWRT_COUNT > OST_COUNT) ?
		PWRT_COUNT : OST_COUNT;
	logic [7:0] cnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Edges since the last power event, saturating so it never wraps
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) cnt_q <= 8'h00;
		else if (por_event || brownout_reset) cnt_q <= 8'h00;
		else if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
	end

	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	sequence long_hold_s;
		!master_clear_pin_n && cnt_q > MAXT + 2;
	endsequence
	sequence pin_free_s;
		master_clear_pin_n && !por_event && !brownout_reset;
	endsequence
	powerup_wait_a: assert property (
		core_rst_n |-> cnt_q >= MAXT)
		else $error("core ran before start-up timers ended");
	pin_hold_a: assert property (
		!master_clear_pin_n |=> !core_rst_n)
		else $error("core ran with master clear held");
	pin_release_a: assert property (
		long_hold_s ##1 pin_free_s |-> ##[1:2] core_rst_n)
		else $error("core not running soon after pin release");
	irq_gate_a: assert property (
		irq_take |-> core_rst_n && core.irq_req)
		else $error("interrupt passed while core in reset");
	viol_now_a: assert property (
		core.exec_valid && !core_rst_n |=> exec_violation_rst)
		else $error("violation reset did not follow execute");
	viol_cause_a: assert property (
		exec_violation_rst |->
		$past(core.exec_valid) && !$past(core_rst_n))
		else $error("violation reset without a blocked execute");
	viol_pulse_a: assert property (
		exec_violation_rst |=> !exec_violation_rst)
		else $error("violation reset longer than one cycle");
	prefetch_quiet_a: assert property (
		!core.exec_valid |=> !exec_violation_rst)
		else $error("violation reset without an execute");
endmodule // srs_seq_checker

bind srs_seq srs_seq_checker #(.PWRT_COUNT(PWRT_COUNT), .OST_COUNT(OST_COUNT),
	.AW(AW)) i_chk (.clk(clk), .nrst(nrst), .por_event(por_event),
	.brownout_reset(brownout_reset), .master_clear_pin_n(master_clear_pin_n),
	.core(core), .core_rst_n(core_rst_n), .irq_take(irq_take),
	.exec_violation_rst(exec_violation_rst), .axi_req(axi_req),
	.axi_rsp(axi_rsp));

//--- test/srs_core_model.sv
/*
 * Far side model: master clear pin driver and core execute stage.
 * Assumes bench commands change just after a rising edge.
 */
`timescale 1ns/10ps
module srs_core_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic core_rst_n,
	input wire logic hold_pin,
	input wire logic go,
	input wire logic [15:0] addr,
	input wire logic irq,
	output logic master_clear_pin_n,
	output srs_pkg::srs_core_s core
);
	// Core only executes while let out of reset; a fetch never executes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			master_clear_pin_n <= 1'b1;
			core <= '0;
		end else begin
			master_clear_pin_n <= !hold_pin;
			core.exec_valid <= go && core_rst_n;
			core.exec_addr <= addr;
			core.irq_req <= irq;
		end
	end
endmodule // srs_core_model

//--- test/tb_startup_and_exec_violation_reset.sv
/*
 * Self-checking bench for srs_seq with short timers.
 * Assumes the checker is bound and the core model sits beside the DUT.
 */
`timescale 1ns/10ps
module tb_startup_and_exec_violation_reset;
	logic clk = 0, nrst = 0, por_event = 0, brownout_reset = 0;
	logic hold_pin = 0, go = 0, irq = 0, master_clear_pin_n, core_rst_n;
	logic irq_take, exec_violation_rst;
	logic [15:0] addr = 16'h0000;
	logic [31:0] r;
	logic [1:0] s;
	srs_pkg::srs_core_s core;
	srs_pkg::srs_axi_req_s q = '0;
	srs_pkg::srs_axi_rsp_s rsp;
	int mismatches = 0, check_count = 0;

	always #50 clk = ~clk;

	srs_seq #(.PWRT_COUNT(4), .OST_COUNT(6)) i_dut (.clk(clk), .nrst(nrst),
		.por_event(por_event), .brownout_reset(brownout_reset),
		.master_clear_pin_n(master_clear_pin_n), .core(core),
		.core_rst_n(core_rst_n), .irq_take(irq_take),
		.exec_violation_rst(exec_violation_rst), .axi_req(q), .axi_rsp(rsp));
	srs_core_model i_core (.clk(clk), .nrst(nrst), .core_rst_n(core_rst_n),
		.hold_pin(hold_pin), .go(go), .addr(addr), .irq(irq),
		.master_clear_pin_n(master_clear_pin_n), .core(core));

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One AXI4-Lite transfer; readies are read at the falling edge
	task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ra, rw, v;
		@(posedge clk);
		q.awaddr <= a; q.araddr <= a; q.wdata <= d; q.wstrb <= 4'hF;
		q.awvalid <= w; q.wvalid <= w; q.arvalid <= !w;
		q.bready <= w; q.rready <= !w;
		for (n = 0; n < 50; n++) begin
			// Registered answers settle mid-cycle and hold to the edge
			@(negedge clk);
			ra = w ? rsp.awready : rsp.arready;
			rw = rsp.wready;
			v = w ? rsp.bvalid : rsp.rvalid;
			r = rsp.rdata;
			s = w ? rsp.bresp : rsp.rresp;
			@(posedge clk);
			if (ra === 1'b1) begin
				q.awvalid <= 0;
				q.arvalid <= 0;
			end
			if (rw === 1'b1) begin
				q.wvalid <= 0;
			end
			if (v === 1'b1) break;
		end
		q.bready <= 0;
		q.rready <= 0;
		if (n == 50) begin
			mismatches++;
			print_verdict();
		end
	endtask

	// Falling edges until the core runs; a hang ends the run
	task automatic run_wait(output int k);
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			if (core_rst_n === 1'b1) break;
		end
		if (k == 40) begin
			mismatches++;
			print_verdict();
		end
	endtask

	// One execute (or a mere fetch when g is low) with an interrupt beside it
	task automatic exe(input logic [15:0] a, input logic g, input logic ev);
		logic seen;
		int i;
		seen = 0;
		@(posedge clk);
		addr <= a; go <= g; irq <= 1;
		@(posedge clk);
		go <= 0; irq <= 0;
		for (i = 0; i < 4; i++) begin
			@(negedge clk);
			if (core.exec_valid === 1'b1 && core_rst_n === 1'b0) begin
				chk(irq_take, 0);
			end
			// A legal execute lets the interrupt through
			if (core.exec_valid === 1'b1 && core_rst_n === 1'b1) begin
				chk(irq_take, 1);
			end
			if (exec_violation_rst === 1'b1) seen = 1;
		end
		chk(seen, ev);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_powerup();
		int k;
		@(posedge clk);
		por_event <= 1;
		@(posedge clk);
		por_event <= 0;
		run_wait(k);
		chk(k >= 5 && k <= 9, 1);
		bus(0, srs_pkg::OFS_STAT, 0);
		chk(r, 32'h0000_0007);
	endtask

	task automatic t_regs();
		bus(0, srs_pkg::OFS_POWER_CONTROL_REG_1, 0);
		chk(r, 32'h0000_0002);
		bus(0, srs_pkg::OFS_CFG, 0);
		chk(r, 32'h0000_0007);
		bus(0, srs_pkg::OFS_LIMIT, 0);
		chk(r, 32'h0000_8000);
		bus(0, srs_pkg::OFS_SAF_BASE, 0);
		chk(r, 32'h0000_7F80);
		bus(0, 8'h20, 0);
		chk(r, 32'h0000_0000);
		chk({30'h0, s}, {30'h0, srs_pkg::RESP_SLVERR});
		bus(1, 8'h20, 32'h0000_0001);
		chk({30'h0, s}, {30'h0, srs_pkg::RESP_SLVERR});
	endtask

	// Valid, invalid, fetch-only and storage-area executes
	task automatic t_exec();
		exe(16'h0100, 1, 0);
		exe(16'h8000, 1, 1);
		bus(0, srs_pkg::OFS_POWER_CONTROL_REG_1, 0);
		chk(r[1], 0);
		bus(1, srs_pkg::OFS_POWER_CONTROL_REG_1, 32'h0000_0002);
		chk({30'h0, s}, {30'h0, srs_pkg::RESP_OKAY});
		bus(0, srs_pkg::OFS_POWER_CONTROL_REG_1, 0);
		chk(r[1], 1);
		exe(16'hFFFF, 0, 0);
		bus(1, srs_pkg::OFS_CFG, 32'h0000_000F);
		exe(16'h7F80, 1, 1);
		exe(16'h7F7F, 1, 0);
		bus(1, srs_pkg::OFS_CFG, 32'h0000_0007);
		exe(16'h7F80, 1, 0);
	endtask

	// Pin held past both timers, then released
	task automatic t_master_clear_pin();
		int k;
		// Drive the pin from a rising edge, not from the last negedge
		@(posedge clk);
		hold_pin <= 1;
		@(posedge clk);
		brownout_reset <= 1;
		@(posedge clk);
		brownout_reset <= 0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk(core_rst_n, 0);
		bus(0, srs_pkg::OFS_STAT, 0);
		chk(r, 32'h0000_0003);
		hold_pin <= 0;
		run_wait(k);
		chk(k <= 3, 1);
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1;
		t_powerup();
		t_regs();
		t_exec();
		t_master_clear_pin();
		print_verdict();
	end
endmodule // tb_startup_and_exec_violation_reset
